// ==== logic/mtb_pkg.sv ====
// Package with constants and types for the memory timing bus controller
package mtb_pkg;
  // Clock period and the DRAM time slot
  localparam int CLK_NS = 100;
  localparam int SLOT_NS = 250;
  localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  // Refresh interval, a longest time, so rounded down
  localparam int REFRESH_NS = 15000;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
  // Clock divider counter width and tap positions
  localparam int DIV_W = 5;
  localparam int DIV8_BIT = 0;
  localparam int DIV4_BIT = 1;
  localparam int DIV500K_BIT = 4;
  // DRAM address field positions (64-bit words, 9 row and 9 column bits)
  localparam int DRAM_AW = 9;
  localparam int HALF_BIT = 2;
  localparam int COL_LSB = 3;
  localparam int ROW_LSB = 12;
  // Video pointer step per 64-bit fetch
  localparam logic [31:0] VID_STEP = 32'h0000_0008;
  // Monitor rate reset value
  localparam logic [1:0] RATE_RESET = 2'h0;

  // Monitor timing selection
  typedef enum logic [1:0] {
    MTB_RATE_50,
    MTB_RATE_60,
    MTB_RATE_71
  } mtb_rate_e;

  // DRAM control pins
  typedef struct packed {
    logic ras_n;
    logic [1:0] cas_n;
    logic we_n;
    logic [DRAM_AW-1:0] addr;
  } mtb_dram_s;

  // Chip selects from the address decoder
  typedef struct packed {
    logic serial;
    logic multifunction_peripheral;
    logic dma_controller_chip;
    logic sound_generator_chip;
    logic memctl;
    logic rom;
    logic ram;
  } mtb_sel_s;

  localparam mtb_dram_s DRAM_IDLE = '{ras_n: 1'b1, cas_n: 2'h3, we_n: 1'b1,
                                      addr: '0};
endpackage : mtb_pkg

// ==== logic/mtb_controller.sv ====
// Memory, timing and bus controller: DRAM slots, dividers, decode
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Alternate video and processor DRAM use in fixed 250 ns slots; here 3 clocks of 100 ns, so 300 ns.
// - Hold processor DRAM access off while a display fetch slot runs.
// - A held processor access gets the slot right after the video slot.
// - DRAM data path is 64 bits; video fetches move 64 bits.
// - Processor accesses use a 32-bit half of the DRAM path.
// - Divide the input clock into 4 MHz, 8 MHz and 500 kHz outputs; at the 100 ns clock they give 2.5 MHz, 5 MHz and 312.5 kHz.
// - Video chip sync and display enable schedule fetches and refresh.
// - Readable, writable monitor timing setting of 50, 60 or 71 Hz.
// - Arbitrate bus ownership so processor and DMA never drive together.
// - Split bus address into row and column with RAS and CAS strobes.
// - Refresh DRAM, load video shifter, move data during DMA cycles.
// - Decode selects for serial, peripheral, DMA, sound, memctl, ROM.
// - Peripheral, DMA and memory acknowledges pace and end transfers.
// - Enable DRAM or ROM only for addresses inside their ranges.
module mtb_controller #(
  parameter logic [31:0] RAM_BASE = 32'h0000_0000,
  parameter logic [31:0] RAM_SIZE = 32'h0020_0000,
  parameter logic [31:0] ROM_BASE = 32'h00E0_0000,
  parameter logic [31:0] ROM_SIZE = 32'h0008_0000,
  parameter logic [31:0] SERIAL_BASE = 32'h00FF_FC00,
  parameter logic [31:0] MFP_BASE = 32'h00FF_FA00,
  parameter logic [31:0] DMA_BASE = 32'h00FF_8600,
  parameter logic [31:0] SOUND_BASE = 32'h00FF_8800,
  parameter logic [31:0] MEMCTL_BASE = 32'h00FF_8000,
  parameter logic [31:0] IO_SIZE = 32'h0000_0100
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // System bus, driven by whichever master holds the grant
  input wire logic bus_req_in,
  input wire logic bus_we_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  output logic [31:0] bus_rdata_out,
  output logic bus_ack_out,
  // Bus ownership
  input wire logic dma_bus_req_in,
  output logic cpu_grant_out,
  output logic dma_grant_out,
  // Acknowledges from outside slaves
  input wire logic mfp_ack_in,
  input wire logic dma_ack_in,
  input wire logic periph_ack_in,
  // Chip selects
  output mtb_pkg::mtb_sel_s sel_out,
  // Video chip
  input wire logic display_window_active_in,
  input wire logic vsync_in,
  input wire logic hsync_in,
  input wire logic [31:0] video_base_in,
  output logic [63:0] video_data_out,
  output logic video_load_out,
  // Monitor timing setting
  input wire logic rate_wr_in,
  input wire logic [1:0] rate_in,
  output logic [1:0] rate_out,
  // DRAM
  output mtb_pkg::mtb_dram_s dram_out,
  output logic [63:0] dram_wdata_out,
  input wire logic [63:0] dram_rdata_in,
  // Divided clocks
  output logic clk_8_out,
  output logic clk_4_out,
  output logic clk_500k_out
);

  typedef enum logic [1:0] {
    MTB_ACT_NONE,
    MTB_ACT_FETCH,
    MTB_ACT_REFRESH,
    MTB_ACT_CPU
  } mtb_act_e;

  // Row field of a byte address
  function automatic logic [mtb_pkg::DRAM_AW-1:0] row_of(
    input logic [31:0] a);
    row_of = a[mtb_pkg::ROW_LSB +: mtb_pkg::DRAM_AW];
  endfunction : row_of

  // Column field of a byte address
  function automatic logic [mtb_pkg::DRAM_AW-1:0] col_of(
    input logic [31:0] a);
    col_of = a[mtb_pkg::COL_LSB +: mtb_pkg::DRAM_AW];
  endfunction : col_of

  // Address range test
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] size);
    in_range = (a >= base) && ((a - base) < size);
  endfunction : in_range

  logic [mtb_pkg::DIV_W-1:0] div_cnt;
  logic [1:0] phase;
  logic video_slot;
  mtb_act_e act;
  logic [31:0] act_addr;
  logic act_we;
  logic [31:0] act_wdata;
  logic [31:0] video_ptr;
  logic vsync_prev;
  logic hsync_prev;
  logic [7:0] refresh_cnt;
  logic refresh_due;
  logic dma_owner;
  logic ram_done;
  logic phase_last;
  logic slot_start;
  mtb_act_e next_act;
  logic periph_ack;

  localparam logic [1:0] PHASE_LAST = 2'(mtb_pkg::SLOT_CYC - 1);
  localparam logic [7:0] REFRESH_LAST = 8'(mtb_pkg::REFRESH_CYC - 1);

  assign phase_last = (phase == PHASE_LAST);
  assign slot_start = (phase == 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // Clock dividers

  // Free running divider; taps give /2, /4 and /32 of the input
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign clk_8_out = div_cnt[mtb_pkg::DIV8_BIT];
  assign clk_4_out = div_cnt[mtb_pkg::DIV4_BIT];
  assign clk_500k_out = div_cnt[mtb_pkg::DIV500K_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Monitor timing setting

  // Written by software through the strobe, read back on rate_out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rate_out <= mtb_pkg::RATE_RESET;
    end else if (rate_wr_in && rate_in != 2'h3) begin
      rate_out <= rate_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus arbitration

  // Ownership changes only while the bus carries no request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dma_owner <= 1'b0;
    end else if (!bus_req_in) begin
      dma_owner <= dma_bus_req_in;
    end
  end

  assign cpu_grant_out = !dma_owner && !(dma_bus_req_in && !bus_req_in);
  assign dma_grant_out = dma_owner && dma_bus_req_in;

  ////////////////////////////////////////////////////////////////////////
  // Address decoding

  // Selects follow the address while a request is on the bus
  always_comb begin
    sel_out = '0;
    if (bus_req_in) begin
      sel_out.serial = in_range(bus_addr_in, SERIAL_BASE, IO_SIZE);
      sel_out.multifunction_peripheral =
        in_range(bus_addr_in, MFP_BASE, IO_SIZE);
      sel_out.dma_controller_chip = in_range(bus_addr_in, DMA_BASE, IO_SIZE);
      sel_out.sound_generator_chip =
        in_range(bus_addr_in, SOUND_BASE, IO_SIZE);
      sel_out.memctl = in_range(bus_addr_in, MEMCTL_BASE, IO_SIZE);
      sel_out.rom = in_range(bus_addr_in, ROM_BASE, ROM_SIZE);
      sel_out.ram = in_range(bus_addr_in, RAM_BASE, RAM_SIZE);
    end
  end

  // MFP and DMA end transfers with their own acknowledge; serial, sound, memctl and ROM share periph_ack_in
  assign periph_ack = (sel_out.multifunction_peripheral && mfp_ack_in) ||
                      (sel_out.dma_controller_chip && dma_ack_in) ||
                      ((sel_out.serial || sel_out.sound_generator_chip ||
                        sel_out.memctl || sel_out.rom) && periph_ack_in);
  assign bus_ack_out = ram_done || periph_ack;

  ////////////////////////////////////////////////////////////////////////
  // Slot timing

  // Phase counter spans one slot; slot kind alternates every slot
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase <= 2'h0;
      video_slot <= 1'b1;
    end else if (phase_last) begin
      phase <= 2'h0;
      video_slot <= !video_slot;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Refresh interval timer; hsync also asks for a refresh; set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      refresh_cnt <= '0;
      refresh_due <= 1'b0;
      hsync_prev <= 1'b0;
    end else begin
      hsync_prev <= hsync_in;
      refresh_cnt <= (refresh_cnt == REFRESH_LAST) ? 8'h00 :
                     refresh_cnt + 8'h01;
      if (refresh_cnt == REFRESH_LAST || (hsync_in && !hsync_prev)) begin
        refresh_due <= 1'b1;
      end else if (slot_start && next_act == MTB_ACT_REFRESH) begin
        refresh_due <= 1'b0;
      end
    end
  end

  // Choose the work of a slot at its start
  always_comb begin
    next_act = MTB_ACT_NONE;
    if (video_slot) begin
      if (display_window_active_in) begin
        next_act = MTB_ACT_FETCH;
      end else if (refresh_due) begin
        next_act = MTB_ACT_REFRESH;
      end
    end else if (bus_req_in && sel_out.ram && !ram_done) begin
      next_act = MTB_ACT_CPU;
    end
  end

  // Latch the chosen access for the whole slot
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      act <= MTB_ACT_NONE;
      act_addr <= '0;
      act_we <= 1'b0;
      act_wdata <= '0;
    end else if (slot_start) begin
      act <= next_act;
      act_addr <= (next_act == MTB_ACT_FETCH) ? video_ptr : bus_addr_in;
      act_we <= (next_act == MTB_ACT_CPU) && bus_we_in;
      act_wdata <= bus_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // DRAM strobes

  // Row then column for accesses; CAS before RAS for refresh
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dram_out <= mtb_pkg::DRAM_IDLE;
      dram_wdata_out <= '0;
    end else begin
      dram_out <= mtb_pkg::DRAM_IDLE;
      dram_wdata_out <= {act_wdata, act_wdata};
      if (slot_start) begin
        if (next_act == MTB_ACT_REFRESH) begin
          dram_out.cas_n <= 2'h0;
        end else if (next_act != MTB_ACT_NONE) begin
          dram_out.ras_n <= 1'b0;
          dram_out.addr <= row_of((next_act == MTB_ACT_FETCH) ?
                                  video_ptr : bus_addr_in);
        end
      end else if (!phase_last && act != MTB_ACT_NONE) begin
        dram_out.ras_n <= 1'b0;
        if (act == MTB_ACT_REFRESH) begin
          dram_out.cas_n <= 2'h0;
        end else begin
          dram_out.addr <= col_of(act_addr);
          dram_out.we_n <= !act_we;
          if (act == MTB_ACT_FETCH) begin
            dram_out.cas_n <= 2'h0;
          end else begin
            dram_out.cas_n <= act_addr[mtb_pkg::HALF_BIT] ? 2'h1 : 2'h2;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data return

  // Processor or DMA data: one 32-bit half; acknowledged at slot end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_rdata_out <= '0;
      ram_done <= 1'b0;
    end else begin
      ram_done <= 1'b0;
      if (phase_last && act == MTB_ACT_CPU) begin
        ram_done <= 1'b1;
        bus_rdata_out <= act_addr[mtb_pkg::HALF_BIT] ?
                         dram_rdata_in[63:32] : dram_rdata_in[31:0];
      end
    end
  end

  // Video fetch: whole 64-bit word into the shifter, pointer advances
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      video_data_out <= '0;
      video_load_out <= 1'b0;
      video_ptr <= '0;
      vsync_prev <= 1'b0;
    end else begin
      vsync_prev <= vsync_in;
      video_load_out <= 1'b0;
      if (vsync_in && !vsync_prev) begin
        video_ptr <= video_base_in;
      end else if (phase_last && act == MTB_ACT_FETCH) begin
        video_ptr <= video_ptr + mtb_pkg::VID_STEP;
      end
      if (phase_last && act == MTB_ACT_FETCH) begin
        video_data_out <= dram_rdata_in;
        video_load_out <= 1'b1;
      end
    end
  end

endmodule : mtb_controller

`default_nettype wire

// ==== test/mtb_far_side.sv ====
// DRAM array and slave acknowledge model
`timescale 1ns/100ps
`default_nettype none
module mtb_far_side (
  input wire logic clk_in,
  input wire mtb_pkg::mtb_dram_s dram_in,
  input wire logic [63:0] wdata_in,
  input wire mtb_pkg::mtb_sel_s sel_in,
  input wire logic slow_in,
  output logic [63:0] rdata_out,
  output logic mfp_ack_out,
  output logic dma_ack_out,
  output logic periph_ack_out
);
  logic [63:0] mem [2**18];
  logic [8:0] row;
  logic cbr;
  logic go;
  int wait_cnt;
  assign go = sel_in != '0 && wait_cnt >= (slow_in ? 4 : 0);
  logic [63:0] held;
  logic drive;
  // Column strobe low outside refresh puts the word on the data lines
  assign drive = !dram_in.ras_n && dram_in.cas_n != 2'h3 && !cbr;
  // Read data flows while CAS is low, as in an asynchronous part
  assign rdata_out = drive ? mem[{row, dram_in.addr}] : ~held;
  // Row at RAS, write at CAS, data garbled once released
  always_ff @(posedge clk_in) begin
    cbr <= dram_in.ras_n && dram_in.cas_n != 2'h3;
    held <= rdata_out;
    if (!dram_in.ras_n && dram_in.cas_n == 2'h3) row <= dram_in.addr;
    if (drive) begin
      if (!dram_in.we_n && !dram_in.cas_n[1])
        mem[{row, dram_in.addr}][63:32] <= wdata_in[63:32];
      if (!dram_in.we_n && !dram_in.cas_n[0])
        mem[{row, dram_in.addr}][31:0] <= wdata_in[31:0];
    end
  end
  // Slaves answer a held select promptly or late
  always_ff @(posedge clk_in) begin
    wait_cnt <= (sel_in == '0) ? 0 : wait_cnt + 1;
    mfp_ack_out <= go && sel_in.multifunction_peripheral;
    dma_ack_out <= go && sel_in.dma_controller_chip;
    periph_ack_out <= go && (sel_in.serial || sel_in.sound_generator_chip ||
      sel_in.memctl || sel_in.rom);
  end
endmodule : mtb_far_side
`default_nettype wire

// ==== test/mtb_controller_properties.sv ====
// Port checker of the memory timing bus controller
`timescale 1ns/100ps
`default_nettype none
module mtb_controller_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic bus_req_in,
  input wire logic bus_ack_out,
  input wire logic cpu_grant_out,
  input wire logic dma_grant_out,
  input wire logic mfp_ack_in,
  input wire logic periph_ack_in,
  input wire mtb_pkg::mtb_sel_s sel_out,
  input wire logic video_load_out,
  input wire logic rate_wr_in,
  input wire logic [1:0] rate_in,
  input wire logic [1:0] rate_out,
  input wire mtb_pkg::mtb_dram_s dram_out,
  input wire logic clk_8_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  grant_excl_a: assert property (!(cpu_grant_out && dma_grant_out))
    else $error("both masters granted");
  ram_wait_a: assert property ($rose(sel_out.ram) |-> ##[3:9] bus_ack_out)
    else $error("ram access not served in time");
  ram_half_a: assert property (bus_ack_out && sel_out.ram |->
    $past(dram_out.cas_n) inside {2'h1, 2'h2})
    else $error("ram ack without half column strobe");
  video_word_a: assert property (video_load_out |->
    $past(dram_out.cas_n) == 2'h0)
    else $error("video load without full word strobe");
  periph_ack_a: assert property (bus_req_in && (sel_out.serial &&
    periph_ack_in || sel_out.multifunction_peripheral && mfp_ack_in)
    |-> bus_ack_out)
    else $error("slave ack not passed on");
  unmapped_a: assert property (sel_out == '0 |-> !bus_ack_out)
    else $error("ack without select");
  sel_idle_a: assert property (!bus_req_in |-> sel_out == '0)
    else $error("select without request");
  rate_set_a: assert property (rate_wr_in && rate_in != 2'h3 |=>
    rate_out == $past(rate_in))
    else $error("rate not taken");
  div8_a: assert property (!$past(rst_in) && !$past(rst_in, 2) |->
    clk_8_out != $past(clk_8_out))
    else $error("half rate clock stuck");
endmodule : mtb_controller_properties
bind mtb_controller mtb_controller_properties i_props (.clk_in(clk_in),
  .rst_in(rst_in), .bus_req_in(bus_req_in), .bus_ack_out(bus_ack_out),
  .cpu_grant_out(cpu_grant_out), .dma_grant_out(dma_grant_out),
  .mfp_ack_in(mfp_ack_in), .periph_ack_in(periph_ack_in), .sel_out(sel_out),
  .video_load_out(video_load_out), .rate_wr_in(rate_wr_in),
  .rate_in(rate_in), .rate_out(rate_out), .dram_out(dram_out),
  .clk_8_out(clk_8_out));
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the memory timing bus controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [31:0] addr;
    logic [6:0] sel;
  } mtb_row_s;
  logic clk_in, rst_in, bus_req_in, bus_we_in, dma_bus_req_in, slow, ok;
  logic display_window_active_in, vsync_in, hsync_in, rate_wr_in;
  logic [31:0] bus_addr_in, bus_wdata_in, bus_rdata_out, video_base_in, rd;
  logic [1:0] rate_in, rate_out;
  logic bus_ack_out, cpu_grant_out, dma_grant_out, mfp_ack_in, dma_ack_in;
  logic periph_ack_in, video_load_out, clk_8_out, clk_4_out, clk_500k_out;
  logic [63:0] video_data_out, dram_wdata_out, dram_rdata_in;
  logic [6:0] sel_seen;
  logic [2:0] p;
  mtb_pkg::mtb_sel_s sel_out;
  mtb_pkg::mtb_dram_s dram_out;
  int error_cnt = 0;
  int check_count = 0;
  int n8, n4, n500;
  mtb_row_s rows [8] = '{'{32'h00FF_FC04, 7'h40}, '{32'h00FF_FA10, 7'h20},
    '{32'h00FF_8604, 7'h10}, '{32'h00FF_8800, 7'h08}, '{32'h00FF_80FC, 7'h04},
    '{32'h00E7_FFFC, 7'h02}, '{32'h0000_0010, 7'h01}, '{32'h00E8_0000, 7'h00}};
  mtb_controller i_mtb_controller (.clk_in(clk_in), .rst_in(rst_in),
    .bus_req_in(bus_req_in), .bus_we_in(bus_we_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
    .bus_ack_out(bus_ack_out), .dma_bus_req_in(dma_bus_req_in),
    .cpu_grant_out(cpu_grant_out), .dma_grant_out(dma_grant_out),
    .mfp_ack_in(mfp_ack_in), .dma_ack_in(dma_ack_in),
    .periph_ack_in(periph_ack_in), .sel_out(sel_out),
    .display_window_active_in(display_window_active_in),
    .vsync_in(vsync_in), .hsync_in(hsync_in), .video_base_in(video_base_in),
    .video_data_out(video_data_out), .video_load_out(video_load_out),
    .rate_wr_in(rate_wr_in), .rate_in(rate_in), .rate_out(rate_out),
    .dram_out(dram_out), .dram_wdata_out(dram_wdata_out),
    .dram_rdata_in(dram_rdata_in), .clk_8_out(clk_8_out),
    .clk_4_out(clk_4_out), .clk_500k_out(clk_500k_out));
  mtb_far_side i_mtb_far_side (.clk_in(clk_in), .dram_in(dram_out),
    .wdata_in(dram_wdata_out), .sel_in(sel_out), .slow_in(slow),
    .rdata_out(dram_rdata_in), .mfp_ack_out(mfp_ack_in),
    .dma_ack_out(dma_ack_in), .periph_ack_out(periph_ack_in));
  //////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #3000000;
    error_cnt++;
    final_report();
  end
  // Compare and verdict
  task automatic chk(input string what, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // One bus transfer, held until acknowledged or given up
  task automatic bus(input logic we, input logic [31:0] a, d);
    int n = 0;
    @(posedge clk_in);
    bus_req_in <= 1'b1;
    bus_we_in <= we;
    bus_addr_in <= a;
    bus_wdata_in <= d;
    @(negedge clk_in);
    sel_seen = sel_out;
    while (bus_ack_out !== 1'b1 && n < 12) begin
      @(negedge clk_in);
      n++;
    end
    ok = bus_ack_out;
    rd = bus_rdata_out;
    @(posedge clk_in);
    bus_req_in <= 1'b0;
  endtask : bus
  task automatic wait_load();
    int n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (video_load_out !== 1'b1 && n < 20);
  endtask : wait_load
  //////////////////////////////////////////
  // Main sequence
  initial begin
    {bus_req_in, bus_we_in, dma_bus_req_in, slow, display_window_active_in,
      vsync_in, hsync_in, rate_wr_in, rate_in} = '0;
    {bus_addr_in, bus_wdata_in, video_base_in} = '0;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      slow <= i[0];
      bus(1'b0, rows[i].addr, 32'h0);
      chk("select", sel_seen, rows[i].sel);
      chk("ack", ok, rows[i].sel != 7'h0);
    end
    for (int i = 0; i < 4; i++) bus(1'b1, 32'h100 + 4 * i, 32'h1111_1111 * (i + 1));
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 32'h100 + 4 * i, 32'h0);
      chk("ram read", rd, 32'h1111_1111 * (i + 1));
    end
    // Display fetches from a new frame base, processor squeezed between
    video_base_in <= 32'h100;
    vsync_in <= 1'b1;
    hsync_in <= 1'b1;
    @(posedge clk_in);
    {vsync_in, hsync_in} <= 2'h0;
    display_window_active_in <= 1'b1;
    wait_load();
    chk("video word", video_data_out, 64'h2222_2222_1111_1111);
    wait_load();
    chk("video next", video_data_out, 64'h4444_4444_3333_3333);
    bus(1'b0, 32'h104, 32'h0);
    chk("read in display", rd, 32'h2222_2222);
    display_window_active_in <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_in);
      rate_wr_in <= 1'b1;
      rate_in <= r[1:0];
      @(posedge clk_in);
      rate_wr_in <= 1'b0;
      @(negedge clk_in);
      chk("rate", rate_out, (r == 3) ? 2'h2 : r[1:0]);
    end
    {n8, n4, n500} = '0;
    repeat (64) begin
      p = {clk_8_out, clk_4_out, clk_500k_out};
      @(negedge clk_in);
      n8 += int'(p[2] != clk_8_out);
      n4 += int'(p[1] != clk_4_out);
      n500 += int'(p[0] != clk_500k_out);
    end
    chk("half rate clock", n8, 64);
    chk("quarter rate clock", n4, 32);
    chk("slow clock", n500, 4);
    // Bus handed to the DMA master and back
    @(posedge clk_in);
    dma_bus_req_in <= 1'b1;
    repeat (2) @(negedge clk_in);
    chk("dma grant", {cpu_grant_out, dma_grant_out}, 2'h1);
    bus(1'b0, 32'h108, 32'h0);
    chk("dma read", rd, 32'h3333_3333);
    dma_bus_req_in <= 1'b0;
    repeat (2) @(negedge clk_in);
    chk("cpu grant", {cpu_grant_out, dma_grant_out}, 2'h2);
    // Second reset in mid-run
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(negedge clk_in);
    chk("reset state", {rate_out, bus_ack_out, video_load_out, dram_out},
      {4'h0, mtb_pkg::DRAM_IDLE});
    // Release again; memory must survive and slots restart cleanly
    @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, 32'h100, 32'h0);
    chk("read after reset", rd, 32'h1111_1111);
    chk("ack after reset", ok, 1'b1);
    final_report();
  end
endmodule : tb
`default_nettype wire
